// *** include/swk_pkg.sv ***
// Purpose: Shared constants and types of the suspend/wake sequencer
// Assumes: 20 MHz system clock
// Notes:   Offsets are byte addresses on the plain register port
package swk_pkg;
  // ****************************************
  // Register port
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } swk_bus_req_t;

  // ****************************************
  // Control register layout
  // ****************************************
  localparam int unsigned CTRL_SLEEP_EN = 0;
  localparam int unsigned CTRL_FILTER   = 1;
  localparam int unsigned CTRL_PUSHPULL = 2;
  localparam int unsigned CTRL_REINIT   = 3;
  localparam int unsigned CTRL_WCS      = 4;
  localparam int unsigned CTRL_SCS_LO   = 5;
  localparam int unsigned CTRL_PERSIST  = 7;
  localparam int unsigned CTRL_W        = 8;
  // Filter on, all else off, internal oscillator
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h02;

  typedef enum logic [1:0] {
    SCS_CCLK = 2'h0,
    SCS_TCK  = 2'h1,
    SCS_FAB  = 2'h2
  } swk_startup_clk_t;

  // ****************************************
  // Wake counts
  // ****************************************
  localparam int unsigned CNT_W        = 11;
  localparam int unsigned COUNT_UNL_LO = 16;
  localparam logic [CNT_W-1:0] CNT_MIN     = 11'h001;
  localparam logic [CNT_W-1:0] CNT_MAX     = 11'h400;
  localparam logic [CNT_W-1:0] RELEASE_RST = 11'h004;
  localparam logic [CNT_W-1:0] UNLOCK_RST  = 11'h005;

  // Status register layout
  localparam int unsigned ST_STATE_LO = 0;
  localparam int unsigned ST_WAKE_PIN = 3;
  localparam int unsigned ST_RELEASED = 4;
  localparam int unsigned ST_WRITE_EN = 5;
  localparam int unsigned ST_SLEEP    = 6;
  localparam int unsigned ST_CNT_LO   = 16;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ    = 20_000_000;
  localparam longint unsigned NS_PER_S  = 1_000_000_000;
  localparam longint unsigned T_LOCK_NS = 100;
  localparam longint unsigned T_INEN_NS = 200;
  localparam longint unsigned T_FILT_NS = 200;
  localparam int unsigned TMR_W = 4;
  // Least times round up
  localparam longint unsigned LOCK_CYC = (T_LOCK_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam longint unsigned INEN_CYC = (T_INEN_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam longint unsigned FILT_CYC = (T_FILT_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;

  typedef enum logic [2:0] {
    ST_CFG    = 3'h0,
    ST_ACTIVE = 3'h1,
    ST_LOCK   = 3'h3,
    ST_SUSP   = 3'h2,
    ST_INEN   = 3'h6,
    ST_REINIT = 3'h7,
    ST_WAITW  = 3'h5,
    ST_COUNT  = 3'h4
  } swk_state_t;
endpackage

// *** hdl/swk_glitch_filter.sv ***
// Purpose: Optional pulse filter on the synchronised sleep request
// Assumes: Input already synchronised to clk_sys
// Notes:   Bypass gives the raw level with no added delay
`timescale 1ns/1ps
module swk_glitch_filter #(
  parameter int unsigned LEN = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic din,
  output logic      dout
);
  import swk_pkg::*;

  localparam int unsigned CW = $clog2(LEN + 1);

  if (LEN < 1) begin : g_chk
    $error("swk_glitch_filter: LEN must be at least 1");
  end

  typedef struct packed {
    logic          level;
    logic [CW-1:0] run;
  } swk_filt_st_t;

  swk_filt_st_t q;
  swk_filt_st_t d;

  always_comb begin
    d = q;
    if (din == q.level) begin
      d.run = '0;
    end else if (q.run == CW'(LEN - 1)) begin
      // Level accepted only after it has stood LEN cycles
      d.level = din;
      d.run   = '0;
    end else begin
      d.run = q.run + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = enable ? q.level : din;
endmodule // swk_glitch_filter

// *** hdl/swk_sequencer.sv ***
// Purpose: Suspend entry and timed wake-up of the logic device
// Assumes: Pins and foreign clocks sampled here on clk_sys
// Notes:   Wake clock sources are sampled and edge-detected into ticks here, never used as clocks
`timescale 1ns/1ps

module swk_sequencer #(
  parameter int unsigned FILT_LEN = int'(swk_pkg::FILT_CYC),
  parameter int unsigned LOCK_LEN = int'(swk_pkg::LOCK_CYC),
  parameter int unsigned INEN_LEN = int'(swk_pkg::INEN_CYC)
) (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  input  wire swk_pkg::swk_bus_req_t bus,
  output logic [swk_pkg::DATA_W-1:0] rdata,
  input  wire logic                 sleep_req_pin,
  input  wire logic                 cfg_done_pin,
  input  wire logic                 cclk_pin,
  input  wire logic                 tck_pin,
  input  wire logic                 fabric_clk,
  input  wire logic                 wake_pin_i,
  output logic                      wake_pin_o,
  output logic                      wake_pin_oe,
  input  wire logic                 user_wake_o,
  input  wire logic                 user_wake_oe,
  output logic                      user_wake_i,
  output logic                      osc_enable,
  output logic                      inputs_enabled,
  output logic                      outputs_released,
  output logic                      write_enable,
  output logic                      global_reinit
);
  import swk_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (LOCK_LEN < 1 || LOCK_LEN > (1 << TMR_W)) begin : g_chk_lock
    $error("swk_sequencer: LOCK_LEN out of range");
  end
  if (INEN_LEN < 1 || INEN_LEN > (1 << TMR_W)) begin : g_chk_inen
    $error("swk_sequencer: INEN_LEN out of range");
  end

  localparam logic [TMR_W-1:0] LOCK_LOAD = TMR_W'(LOCK_LEN - 1);
  localparam logic [TMR_W-1:0] INEN_LOAD = TMR_W'(INEN_LEN - 1);
  localparam int unsigned NSRC = 3;
  localparam int unsigned SRC_CCLK = 0;
  localparam int unsigned SRC_TCK  = 1;
  localparam int unsigned SRC_FAB  = 2;

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  rel_cnt;
    logic [CNT_W-1:0]  unl_cnt;
    logic [CNT_W-1:0]  wcnt;
    logic [TMR_W-1:0]  tmr;
    swk_state_t        st;
    logic [1:0]        sleep_s;
    logic [1:0]        done_s;
    logic [1:0]        wake_s;
    logic [NSRC-1:0]   src_s1;
    logic [NSRC-1:0]   src_s2;
    logic [NSRC-1:0]   src_prev;
    logic              awake;
    logic              osc;
    logic              inen;
    logic              released;
    logic              gwe;
    logic              gsr;
  } swk_seq_st_t;

  swk_seq_st_t q;
  swk_seq_st_t d;
  logic        sleep_f;

  swk_glitch_filter #(
    .LEN     (FILT_LEN)
  ) u_filter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .enable  (q.ctrl[CTRL_FILTER]),
    .din     (q.sleep_s[1]),
    .dout    (sleep_f)
  );

  // Writes outside 1..1024 are pulled to the nearest legal count
  function automatic logic [CNT_W-1:0] clamp_count(input logic [15:0] v);
    if (v == 16'h0000) begin
      return CNT_MIN;
    end else if (v > 16'(CNT_MAX)) begin
      return CNT_MAX;
    end else begin
      return CNT_W'(v);
    end
  endfunction

  // Picks the wake clock tick; slave persist gates the config clock
  function automatic logic wake_tick(input logic [CTRL_W-1:0] c,
                                     input logic [NSRC-1:0] edges,
                                     input logic osc_run);
    logic use_startup;
    logic [1:0] scs;
    use_startup = c[CTRL_WCS];
    scs         = c[CTRL_SCS_LO +: 2];
    if (!use_startup) begin
      return osc_run;
    end
    unique case (scs)
      SCS_CCLK: return c[CTRL_PERSIST] ? edges[SRC_CCLK] : osc_run;
      SCS_TCK:  return edges[SRC_TCK];
      SCS_FAB:  return edges[SRC_FAB];
      default:  return osc_run;
    endcase
  endfunction

  logic            sleep_act;
  logic [NSRC-1:0] src_edge;
  logic            tick;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d         = q;
    d.rdata   = '0;
    d.gsr     = 1'b0;
    d.sleep_s = {q.sleep_s[0], sleep_req_pin};
    d.done_s  = {q.done_s[0], cfg_done_pin};
    d.wake_s  = {q.wake_s[0], wake_pin_i};
    d.src_s1  = {fabric_clk, tck_pin, cclk_pin};
    d.src_s2  = q.src_s1;
    d.src_prev = q.src_s2;
    src_edge  = q.src_s2 & ~q.src_prev;
    tick      = wake_tick(q.ctrl, src_edge, q.osc);
    // Level, not edge: a request that flips during entry is not lost
    sleep_act = q.ctrl[CTRL_SLEEP_EN] & sleep_f;

    if (bus.wr) begin
      unique case (bus.addr)
        OFS_CTRL: d.ctrl = bus.wdata[CTRL_W-1:0];
        OFS_COUNT: begin
          d.rel_cnt = clamp_count(bus.wdata[15:0]);
          d.unl_cnt = clamp_count(bus.wdata[COUNT_UNL_LO +: 16]);
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_CTRL:  d.rdata[CTRL_W-1:0] = q.ctrl;
        OFS_COUNT: begin
          d.rdata[CNT_W-1:0]                = q.rel_cnt;
          d.rdata[COUNT_UNL_LO +: CNT_W]    = q.unl_cnt;
        end
        OFS_STATUS: begin
          d.rdata[ST_STATE_LO +: 3] = q.st;
          d.rdata[ST_WAKE_PIN]      = q.wake_s[1];
          d.rdata[ST_RELEASED]      = q.released;
          d.rdata[ST_WRITE_EN]      = q.gwe;
          d.rdata[ST_SLEEP]         = sleep_f;
          d.rdata[ST_CNT_LO +: CNT_W] = q.wcnt;
        end
        default: ;
      endcase
    end

    unique case (q.st)
      ST_CFG: begin
        if (q.done_s[1]) begin
          d.inen     = 1'b1;
          d.released = 1'b1;
          d.gwe      = 1'b1;
          if (sleep_act) begin
            // Config finished; suspend at once, wake never rises
            d.st  = ST_LOCK;
            d.tmr = LOCK_LOAD;
          end else begin
            d.st    = ST_ACTIVE;
            d.awake = 1'b1;
          end
        end
      end
      ST_ACTIVE: begin
        if (sleep_act) begin
          d.st  = ST_LOCK;
          d.tmr = LOCK_LOAD;
        end
      end
      ST_LOCK: begin
        if (q.tmr == '0) begin
          // Write lock, wake pin, inputs, outputs and oscillator all go down in the same cycle
          d.gwe      = 1'b0;
          d.awake    = 1'b0;
          d.inen     = 1'b0;
          d.released = 1'b0;
          d.osc      = 1'b0;
          d.wcnt     = '0;
          d.st       = ST_SUSP;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_SUSP: begin
        if (!sleep_act) begin
          d.st  = ST_INEN;
          d.tmr = INEN_LOAD;
          d.osc = 1'b1;
        end
      end
      ST_INEN: begin
        if (q.tmr == '0) begin
          d.inen = 1'b1;
          if (q.ctrl[CTRL_REINIT]) begin
            d.st  = ST_REINIT;
            d.gsr = 1'b1;
          end else begin
            d.st = ST_WAITW;
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_REINIT: begin
        // One-cycle reinit pulse is high in this state and ends with it; wake pin may rise in ST_WAITW
        d.st = ST_WAITW;
      end
      ST_WAITW: begin
        d.awake = 1'b1;
        if (q.wake_s[1]) begin
          d.st = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (q.wake_s[1]) begin
          if (tick && q.wcnt != CNT_MAX) begin
            d.wcnt = q.wcnt + 1'b1;
          end
          if (q.wcnt >= q.rel_cnt) begin
            d.released = 1'b1;
          end
          if (q.wcnt >= q.unl_cnt) begin
            d.gwe = 1'b1;
          end
          if (q.released && q.gwe) begin
            d.st = ST_ACTIVE;
          end
        end
      end
      default: d.st = ST_CFG;
    endcase

    // A new request during wake-up goes straight back to entry
    if (sleep_act && (q.st == ST_INEN || q.st == ST_REINIT ||
                      q.st == ST_WAITW || q.st == ST_COUNT)) begin
      d.st  = ST_LOCK;
      d.tmr = LOCK_LOAD;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.ctrl    <= CTRL_RST;
      q.rel_cnt <= RELEASE_RST;
      q.unl_cnt <= UNLOCK_RST;
      q.st      <= ST_CFG;
      q.osc     <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    if (q.ctrl[CTRL_SLEEP_EN]) begin
      if (q.ctrl[CTRL_PUSHPULL]) begin
        wake_pin_o  = q.awake;
        wake_pin_oe = 1'b1;
      end else begin
        // Open-drain: a pull-up outside must lift the line
        wake_pin_o  = 1'b0;
        wake_pin_oe = ~q.awake;
      end
    end else begin
      wake_pin_o  = user_wake_o;
      wake_pin_oe = user_wake_oe;
    end
  end

  assign user_wake_i = q.wake_s[1];
  assign rdata       = q.rdata;
  assign osc_enable  = q.osc;
  assign inputs_enabled = q.inen;
  // Only user pins are gated; test, done, reprogram pins never pass here
  assign outputs_released = q.released;
  assign write_enable  = q.gwe;
  assign global_reinit = q.gsr;
endmodule // swk_sequencer

// *** verification/swk_sequencer_monitor.sv ***
// Purpose: Concurrent checks on the suspend/wake sequencer ports
// Assumes: One clock domain, clk_sys
// Notes:   Bound to the top module after the module body
`timescale 1ns/1ps
module swk_sequencer_monitor (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wake_pin_i,
  input wire logic wake_pin_o,
  input wire logic wake_pin_oe,
  input wire logic osc_enable,
  input wire logic inputs_enabled,
  input wire logic outputs_released,
  input wire logic write_enable,
  input wire logic global_reinit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_osc_drop_all: assert property ($fell(osc_enable) |-> !write_enable && !outputs_released)
    else $error("oscillator stopped with logic still live");
  a_lock_first: assert property ($fell(inputs_enabled) |-> !write_enable && !wake_pin_o)
    else $error("inputs dropped before write lock");
  a_inputs_first: assert property ($rose(outputs_released) |-> inputs_enabled)
    else $error("outputs released with inputs off");
  a_unlock_live: assert property ($rose(write_enable) |-> inputs_enabled && osc_enable)
    else $error("write lock freed before inputs enabled");
  a_reinit_pulse: assert property (global_reinit |=> !global_reinit)
    else $error("reinit pulse longer than one cycle");
  a_reinit_order: assert property (global_reinit |-> !write_enable && !outputs_released ##1 !write_enable)
    else $error("reinit after wake-up counting");
  a_susp_line_low: assert property (!osc_enable |-> !(wake_pin_oe && wake_pin_o))
    else $error("wake line driven high while suspended");
  a_halt_low: assert property ((!wake_pin_i && inputs_enabled)[*8] |=> !$rose(outputs_released) && !$rose(write_enable))
    else $error("wake counting while line held low");
endmodule // swk_sequencer_monitor

bind swk_sequencer swk_sequencer_monitor swk_sequencer_monitor_i (.clk_sys, .arst_n, .wake_pin_i,
  .wake_pin_o, .wake_pin_oe, .osc_enable, .inputs_enabled, .outputs_released, .write_enable,
  .global_reinit);

// *** verification/swk_far_end.sv ***
// Purpose: Far side: controller, peers and pull-up on the wake line
// Assumes: Source clocks on a clk_sys grid, period four cycles
// Notes:   Held-low line stands for a controller postponing wake-up
`timescale 1ns/1ps
module swk_far_end (
  input  wire logic clk_sys,
  input  wire logic hold_low,
  input  wire logic wake_pin_o,
  input  wire logic wake_pin_oe,
  output logic      wake_pin_i,
  output logic      cclk_pin,
  output logic      tck_pin,
  output logic      fabric_clk
);
  logic [1:0] ph_q = 2'h0;
  always @(posedge clk_sys) ph_q <= ph_q + 2'h1;
  // Test clock never stops, or wake-up would stall
  assign tck_pin    = ph_q[1];
  assign cclk_pin   = ph_q[1];
  // Gated, no flop of its own: locked flops could not toggle
  assign fabric_clk = ph_q[1] & ~hold_low;
  // Pull-up on a wired line; any party may sink it
  assign wake_pin_i = (hold_low || (wake_pin_oe && !wake_pin_o)) ? 1'b0 : 1'b1;
endmodule // swk_far_end

// *** verification/swk_sequencer_bench.sv ***
// Purpose: Self-checking bench of the suspend/wake sequencer
// Assumes: Far-end model owns the wake line and the source clocks
// Notes:   Release to unlock spacing is measured, so sync latency cancels
`timescale 1ns/1ps
module swk_sequencer_bench;
  import swk_pkg::*;
  localparam logic [7:0] CFGS [7] = '{8'h01, 8'h05, 8'h09, 8'h31, 8'h51, 8'h91, 8'h11};
  localparam int         RATE [7] = '{1, 1, 1, 4, 4, 4, 1};
  logic                  clk_sys = 1'b0;
  logic                  arst_n = 1'b0;
  swk_bus_req_t          bus = '0;
  logic [DATA_W-1:0]     rdata;
  logic                  sleep_req_pin = 1'b0;
  logic                  cfg_done_pin = 1'b0;
  logic                  hold_low = 1'b0;
  logic                  ce = 1'b1;
  logic                  user_wake_o = 1'b1;
  logic                  user_wake_oe = 1'b1;
  int                    n_reinit = 0;
  logic                  cclk_pin, tck_pin, fabric_clk, wake_pin_i, wake_pin_o, wake_pin_oe;
  logic                  user_wake_i, osc_enable, inputs_enabled, outputs_released;
  logic                  write_enable, global_reinit;
  integer                seed = 32'ha353a887;
  int                    n_mismatch = 0;
  int                    n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  swk_sequencer swk_sequencer_i (.clk_sys, .arst_n, .ce, .bus, .rdata, .sleep_req_pin,
    .cfg_done_pin, .cclk_pin, .tck_pin, .fabric_clk, .wake_pin_i, .wake_pin_o, .wake_pin_oe,
    .user_wake_o, .user_wake_oe, .user_wake_i, .osc_enable, .inputs_enabled,
    .outputs_released, .write_enable, .global_reinit);
  swk_far_end swk_far_end_i (.clk_sys, .hold_low, .wake_pin_o, .wake_pin_oe, .wake_pin_i,
    .cclk_pin, .tck_pin, .fabric_clk);

  // Reinit pulses seen while still locked and the wake line still low
  always @(posedge clk_sys) begin
    if (global_reinit === 1'b1 && write_enable === 1'b0 && wake_pin_i === 1'b0) begin
      n_reinit <= n_reinit + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_sys) bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_we(input logic v);
    int n;
    n = 0;
    while (write_enable !== v && n < 500) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the run length
  initial begin
    #(50 * 40000);
    n_mismatch++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [10:0] r, u;
    int          tr, n, nr;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFS_CTRL, d);
    chk(d, 32'(CTRL_RST));
    rd(OFS_COUNT, d);
    chk(d, {5'h00, UNLOCK_RST, 5'h00, RELEASE_RST});
    rd(OFS_STATUS, d);
    chk(d & 32'h0000_0007, 32'(ST_CFG));
    @(posedge clk_sys) cfg_done_pin <= 1'b1;
    wait_we(1'b1);
    chk(32'({user_wake_i, write_enable}), 32'h0000_0003);
    // Request pin misused on purpose while the feature is off; wake pin is user I/O
    @(posedge clk_sys) sleep_req_pin <= 1'b1;
    user_wake_o <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 chk(32'({user_wake_i, write_enable, wake_pin_o}), 32'h0000_0002);
    @(posedge clk_sys) sleep_req_pin <= 1'b0;
    user_wake_o <= 1'b1;
    rd(4'hC, d);
    chk(d, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0FFF_0000);
    rd(OFS_COUNT, d);
    chk(d, {5'h00, CNT_MAX, 5'h00, CNT_MIN});
    wr(OFS_CTRL, 32'h0000_0003);
    @(posedge clk_sys) sleep_req_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sleep_req_pin <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk(32'(write_enable), 32'h0000_0001);
    // Strobe must be ignored while the clock enable is low
    ce <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0000);
    ce <= 1'b1;
    rd(OFS_CTRL, d);
    chk(d, 32'h0000_0003);
    for (int i = 0; i < 7; i++) begin
      r = 11'(1 + {$random(seed)} % 6);
      u = r + 11'({$random(seed)} % 4);
      wr(OFS_COUNT, {5'h00, u, 5'h00, r});
      wr(OFS_CTRL, 32'(CFGS[i]));
      nr = n_reinit;
      @(posedge clk_sys) sleep_req_pin <= 1'b1;
      wait_we(1'b0);
      repeat (4) @(posedge clk_sys);
      #1 chk({30'h0, osc_enable, wake_pin_o}, 32'h0000_0000);
      chk(32'(wake_pin_oe), 32'h0000_0001);
      rd(OFS_STATUS, d);
      chk(d & 32'h0000_0007, 32'(ST_SUSP));
      // Push-pull would fight a held line, so only open-drain is held
      @(posedge clk_sys) hold_low <= ~CFGS[i][CTRL_PUSHPULL];
      sleep_req_pin <= 1'b0;
      if (!CFGS[i][CTRL_PUSHPULL]) begin
        repeat (30) @(posedge clk_sys);
        #1 chk({30'h0, outputs_released, write_enable}, 32'h0000_0000);
        rd(OFS_STATUS, d);
        chk(d & 32'h07FF_0007, 32'(ST_WAITW));
        @(posedge clk_sys) hold_low <= 1'b0;
      end
      tr = -1;
      n = 0;
      while (write_enable !== 1'b1 && n < 5000) begin
        @(posedge clk_sys);
        #1 n++;
        if (outputs_released === 1'b1 && tr < 0) tr = n;
      end
      chk(32'(n - tr), 32'(RATE[i] * int'(u - r)));
      chk(32'(n_reinit - nr), 32'(CFGS[i][CTRL_REINIT]));
      chk(32'(wake_pin_oe), 32'(CFGS[i][CTRL_PUSHPULL]));
      rd(OFS_STATUS, d);
      chk(d & 32'h0000_0007, 32'(ST_ACTIVE));
    end
    // Mid-run reset; configuration then completes with the request already high
    @(posedge clk_sys) arst_n <= 1'b0;
    cfg_done_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr(OFS_CTRL, 32'h0000_0001);
    @(posedge clk_sys) sleep_req_pin <= 1'b1;
    cfg_done_pin <= 1'b1;
    repeat (12) @(posedge clk_sys);
    #1 chk({29'h0, write_enable, wake_pin_oe, wake_pin_o}, 32'h0000_0002);
    rd(OFS_STATUS, d);
    chk(d & 32'h0000_0007, 32'(ST_SUSP));
    close_out();
  end
endmodule // swk_sequencer_bench
